// file: design/iorw_defines.svh
// Address map, field positions and timing figures of the I/O read watchdog
`ifndef IORW_DEFINES_SVH
`define IORW_DEFINES_SVH

`define IORW_ADDR_W          16
`define IORW_PORT_DISABLE    16'h0043
`define IORW_PORT_ENABLE     16'h0443

`define IORW_CLK_PERIOD_PS   25000
`define IORW_TICK_NS         1000000
`define IORW_PULSE_NS        1000

`define IORW_PERIOD0_MS      1000
`define IORW_PERIOD1_MS      2000
`define IORW_PERIOD2_MS      5000
`define IORW_PERIOD3_MS      10000
`define IORW_CNT_W           16

`define IORW_ACT_NMI         1'b1
`define IORW_STAT_RUN_BIT    0
`define IORW_STAT_FIRE_BIT   1
`define IORW_STAT_ACT_BIT    2
`define IORW_STAT_PER_LSB    3

`endif

// file: design/iorw_pkg.sv
// Types shared by the I/O read watchdog files
package iorw_pkg;

   typedef enum logic [2:0] {
      IORW_ST_OFF  = 3'b001,
      IORW_ST_RUN  = 3'b010,
      IORW_ST_FIRE = 3'b100
   } iorw_state_t;

   typedef struct packed {
      logic        rd_n;
      logic        action;
      logic [1:0]  period;
      logic [15:0] addr;
   } iorw_pins_t;

   typedef struct packed {
      logic en_hit;
      logic dis_hit;
   } iorw_cmd_t;

endpackage

// file: design/iorw_prescaler.sv
// Millisecond tick generator, restartable so a refresh gives a full period
`timescale 1ns/1ps
`default_nettype none

module iorw_prescaler #(
   parameter int TICK_CYCLES = 40000
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic restart,
   output var  logic tick
);

   localparam int W = $clog2(TICK_CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

   logic [W-1:0] cnt_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (restart || cnt_r == LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= !restart && cnt_r == LAST;
      end
   end

endmodule

`default_nettype wire

// file: design/iorw_watchdog.sv
// Watchdog driven only by host I/O reads of an enable and a disable port
`timescale 1ns/1ps
`default_nettype none
`include "iorw_defines.svh"

// Overview of operation
// R01: A host read of the enable port turns the watchdog on and starts counting.
// R02: A host read of the disable port turns it off; no timeout can follow.
// R03: Each further enable read while running restarts the full period.
// R04: On expiry pulse system reset or NMI, chosen by the action strap.
// R05: The period comes from the period strap, never from software.
// R06: Software refreshes no later than 70 percent of the period.
// R07: Software reads the disable port before its program ends.
// R08: After reset the watchdog is off with no countdown until enabled.
module iorw_watchdog #(
   parameter int TICK_CYCLES = (`IORW_TICK_NS * 1000) / `IORW_CLK_PERIOD_PS,
   parameter int PERIOD0_MS  = `IORW_PERIOD0_MS,
   parameter int PERIOD1_MS  = `IORW_PERIOD1_MS,
   parameter int PERIOD2_MS  = `IORW_PERIOD2_MS,
   parameter int PERIOD3_MS  = `IORW_PERIOD3_MS
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic [`IORW_ADDR_W-1:0]  io_addr,
   input  wire logic                     io_rd_n,
   input  wire logic                     timeout_action_strap,
   input  wire logic [1:0]               timeout_period_strap,
   output var  logic [7:0]               io_data_o,
   output var  logic                     io_data_oe_n,
   output var  logic                     sys_reset_n_o,
   output var  logic                     nmi_o
);

   localparam int PULSE_CYC = (`IORW_PULSE_NS * 1000
                              + `IORW_CLK_PERIOD_PS - 1) / `IORW_CLK_PERIOD_PS;
   localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYC - 1);

   iorw_pkg::iorw_pins_t  pin1_r;
   iorw_pkg::iorw_pins_t  pin2_r;
   logic                  rd_seen_r;
   logic                  rd_fall;
   iorw_pkg::iorw_cmd_t   cmd;
   iorw_pkg::iorw_state_t state_r;
   logic [`IORW_CNT_W-1:0] cnt_r;
   logic [`IORW_CNT_W-1:0] period_ms;
   logic [7:0]            pulse_r;
   logic                  tick;
   logic                  expire;
   logic                  restart;

   // Two-stage capture of every pin; the first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin1_r <= '{rd_n: 1'b1, action: 1'b0, period: 2'h0, addr: 16'h0};
         pin2_r <= '{rd_n: 1'b1, action: 1'b0, period: 2'h0, addr: 16'h0};
      end else begin
         pin1_r <= '{rd_n: io_rd_n, action: timeout_action_strap,
                     period: timeout_period_strap, addr: io_addr};
         pin2_r <= pin1_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_seen_r <= 1'b1;
      end else begin
         rd_seen_r <= pin2_r.rd_n;
      end
   end

   // One command per read cycle, taken at the falling strobe edge
   assign rd_fall     = rd_seen_r && !pin2_r.rd_n;
   assign cmd.en_hit  = rd_fall && pin2_r.addr == `IORW_PORT_ENABLE;   // R01
   assign cmd.dis_hit = rd_fall && pin2_r.addr == `IORW_PORT_DISABLE;  // R02

   always_comb begin
      case (pin2_r.period)                                              // R05
         2'h0:    period_ms = `IORW_CNT_W'(PERIOD0_MS);
         2'h1:    period_ms = `IORW_CNT_W'(PERIOD1_MS);
         2'h2:    period_ms = `IORW_CNT_W'(PERIOD2_MS);
         default: period_ms = `IORW_CNT_W'(PERIOD3_MS);
      endcase
   end

   assign restart = cmd.en_hit && state_r != iorw_pkg::IORW_ST_FIRE;
   assign expire  = state_r == iorw_pkg::IORW_ST_RUN && !cmd.en_hit
                    && !cmd.dis_hit && tick && cnt_r == `IORW_CNT_W'(1);

   iorw_prescaler #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_prescaler (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .restart  (restart),
      .tick     (tick)
   );

   // Fire pulse runs to completion; host reads during it are ignored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= iorw_pkg::IORW_ST_OFF;                              // R08
      end else begin
         case (state_r)
            iorw_pkg::IORW_ST_OFF: begin
               if (cmd.en_hit) begin
                  state_r <= iorw_pkg::IORW_ST_RUN;                     // R01
               end
            end
            iorw_pkg::IORW_ST_RUN: begin
               if (cmd.dis_hit) begin
                  state_r <= iorw_pkg::IORW_ST_OFF;                     // R02
               end else if (expire) begin
                  state_r <= iorw_pkg::IORW_ST_FIRE;                    // R04
               end
            end
            iorw_pkg::IORW_ST_FIRE: begin
               if (pulse_r == PULSE_LAST) begin
                  state_r <= iorw_pkg::IORW_ST_OFF;
               end
            end
            default: state_r <= iorw_pkg::IORW_ST_OFF;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (restart) begin
         cnt_r <= period_ms;                                            // R03
      end else if (cmd.dis_hit || state_r != iorw_pkg::IORW_ST_RUN) begin
         cnt_r <= '0;
      end else if (tick && cnt_r != '0) begin
         cnt_r <= cnt_r - `IORW_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_r <= 8'h00;
      end else if (state_r == iorw_pkg::IORW_ST_FIRE) begin
         pulse_r <= pulse_r + 8'h01;
      end else begin
         pulse_r <= 8'h00;
      end
   end

   // Strap sampled at expiry; it picks the pulse for the whole fire phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_n_o <= 1'b1;
         nmi_o         <= 1'b0;
      end else if (expire) begin
         sys_reset_n_o <= pin2_r.action == `IORW_ACT_NMI;               // R04
         nmi_o         <= pin2_r.action == `IORW_ACT_NMI;               // R04
      end else if (state_r == iorw_pkg::IORW_ST_FIRE
                   && pulse_r == PULSE_LAST) begin
         sys_reset_n_o <= 1'b1;
         nmi_o         <= 1'b0;
      end
   end

   // Read data show live state while either port is being read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_data_oe_n <= 1'b1;
         io_data_o    <= 8'h00;
      end else begin
         io_data_oe_n <= !(!pin2_r.rd_n
                          && (pin2_r.addr == `IORW_PORT_ENABLE
                              || pin2_r.addr == `IORW_PORT_DISABLE));
         io_data_o    <= 8'h00;
         io_data_o[`IORW_STAT_RUN_BIT]  <= state_r == iorw_pkg::IORW_ST_RUN;
         io_data_o[`IORW_STAT_FIRE_BIT] <= state_r == iorw_pkg::IORW_ST_FIRE;
         io_data_o[`IORW_STAT_ACT_BIT]  <= pin2_r.action;
         io_data_o[`IORW_STAT_PER_LSB +: 2] <= pin2_r.period;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   enable_starts_a: assert property (                                  // R01
      state_r == iorw_pkg::IORW_ST_OFF && cmd.en_hit
      |=> state_r == iorw_pkg::IORW_ST_RUN && cnt_r == $past(period_ms))
      else $error("enable read did not start countdown");

   disable_stops_a: assert property (                                  // R02
      state_r == iorw_pkg::IORW_ST_RUN && cmd.dis_hit
      |=> state_r == iorw_pkg::IORW_ST_OFF ##1
          (sys_reset_n_o && !nmi_o && state_r != iorw_pkg::IORW_ST_FIRE))
      else $error("disable read did not stop watchdog");

   refresh_reload_a: assert property (                                 // R03
      state_r == iorw_pkg::IORW_ST_RUN && cmd.en_hit
      |=> cnt_r == $past(period_ms) && state_r == iorw_pkg::IORW_ST_RUN)
      else $error("refresh did not reload full period");

   expire_reset_a: assert property (                                   // R04
      expire && pin2_r.action != `IORW_ACT_NMI
      |=> (!sys_reset_n_o && !nmi_o
           && state_r == iorw_pkg::IORW_ST_FIRE) [*8])
      else $error("reset pulse missing on expiry");

   expire_nmi_a: assert property (                                     // R04
      expire && pin2_r.action == `IORW_ACT_NMI
      |=> nmi_o && sys_reset_n_o)
      else $error("nmi missing on expiry");

   fire_active_a: assert property (                                    // R04
      state_r == iorw_pkg::IORW_ST_FIRE |-> !sys_reset_n_o || nmi_o)
      else $error("fire phase without timeout action");

   pulse_length_a: assert property (                                   // R04
      state_r == iorw_pkg::IORW_ST_FIRE && pulse_r == PULSE_LAST
      |=> state_r == iorw_pkg::IORW_ST_OFF && sys_reset_n_o && !nmi_o)
      else $error("fire pulse wrong length");

   period_strap_a: assert property (                                   // R05
      restart && pin2_r.period == 2'h0
      |=> cnt_r == `IORW_CNT_W'(PERIOD0_MS))
      else $error("period not taken from strap");

   off_quiet_a: assert property (                                      // R08
      state_r == iorw_pkg::IORW_ST_OFF
      |-> sys_reset_n_o && !nmi_o && cnt_r == '0)
      else $error("watchdog acting while off");

   fire_nmi_c: cover property (expire && pin2_r.action == `IORW_ACT_NMI);
   fire_reset_c: cover property (expire && pin2_r.action != `IORW_ACT_NMI);
   refresh_c: cover property (
      state_r == iorw_pkg::IORW_ST_RUN && cmd.en_hit);
   disable_c: cover property (
      state_r == iorw_pkg::IORW_ST_RUN && cmd.dis_hit);

endmodule

`default_nettype wire

// file: testbench/iorw_host_model.sv
// Host processor model that issues I/O port reads to the watchdog
`timescale 1ns/1ps
`default_nettype none

module iorw_host_model (
   input  wire logic        core_clk,
   input  wire logic [7:0]  io_data_o,
   input  wire logic        io_data_oe_n,
   output var  logic [15:0] io_addr,
   output var  logic        io_rd_n
);
   initial begin
      io_addr = 16'h0000;
      io_rd_n = 1'b1;
   end

   // One read cycle; strobe low and high well above three clocks
   task automatic rd(input logic [15:0] a, output logic [7:0] d,
                     output logic oe);
      @(negedge core_clk);
      io_addr = a;
      io_rd_n = 1'b0;
      repeat (6) @(negedge core_clk);
      oe = ~io_data_oe_n;
      // Undriven data bus never shows a valid value
      d = io_data_oe_n ? ~io_data_o : io_data_o;
      io_rd_n = 1'b1;
      repeat (3) @(negedge core_clk);
      io_addr = ~a;
      repeat (3) @(negedge core_clk);
   endtask
endmodule

`default_nettype wire

// file: testbench/iorw_watchdog_tb.sv
// Self-checking testbench of the I/O read watchdog
`timescale 1ns/1ps
`default_nettype none

module iorw_watchdog_tb;
   logic        core_clk, rst_n, act, io_rd_n, oe;
   logic        io_data_oe_n, sys_reset_n_o, nmi_o;
   logic [1:0]  per;
   logic [15:0] io_addr;
   logic [7:0]  io_data_o, d;
   logic [31:0] rnd;
   int          miscompares, total_checks, cyc, fires, t0, f0;

   iorw_watchdog #(.TICK_CYCLES(10), .PERIOD0_MS(3), .PERIOD1_MS(4),
      .PERIOD2_MS(5), .PERIOD3_MS(6)) iorw_watchdog_inst (
      .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
      .io_rd_n(io_rd_n), .timeout_action_strap(act),
      .timeout_period_strap(per), .io_data_o(io_data_o),
      .io_data_oe_n(io_data_oe_n), .sys_reset_n_o(sys_reset_n_o),
      .nmi_o(nmi_o));

   iorw_host_model iorw_host_model_inst (.core_clk(core_clk),
      .io_data_o(io_data_o), .io_data_oe_n(io_data_oe_n),
      .io_addr(io_addr), .io_rd_n(io_rd_n));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [7:0] status(input logic r, input logic a,
                                         input logic [1:0] p);
      return {3'h0, p, a, 1'b0, r};
   endfunction

   task automatic cmp_v(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic cmp_rng(input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         miscompares++;
         $display("mismatch t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
      end
   endtask

   task automatic end_sim;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic set_straps(input logic [1:0] p, input logic a);
      per = p;
      act = a;
      repeat (5) @(negedge core_clk);
   endtask

   // No timeout action may appear within n cycles
   task automatic quiet(input int n);
      f0 = fires;
      repeat (n) @(negedge core_clk);
      cmp_v(8'h00, 8'(fires - f0));
   endtask

   task automatic fire_run(input logic [1:0] p, input logic a);
      int w;
      set_straps(p, a);
      t0 = cyc;
      iorw_host_model_inst.rd(16'h0443, d, oe);
      while (sys_reset_n_o === 1'b1 && nmi_o === 1'b0 && cyc - t0 < 200)
         @(negedge core_clk);
      cmp_rng(10 * (3 + p) + 4, 10 * (3 + p) + 11, cyc - t0);
      cmp_v(a ? 8'h02 : 8'h01, {6'h0, nmi_o, ~sys_reset_n_o});
      w = 0;
      while ((sys_reset_n_o === 1'b0 || nmi_o === 1'b1) && w < 100) begin
         @(negedge core_clk);
         w++;
      end
      cmp_rng(40, 40, w);
      quiet(100);
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (sys_reset_n_o !== 1'b1 || nmi_o !== 1'b0)
         fires <= fires + 1;
   end

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial begin
      #(25 * 20000);
      miscompares++;
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      act = 1'b0;
      per = 2'h0;
      rnd = 32'hf312;
      miscompares = 0;
      total_checks = 0;
      cyc = 0;
      fires = 0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      quiet(100);
      set_straps(2'h2, 1'b1);
      iorw_host_model_inst.rd(16'h0043, d, oe);
      cmp_v(status(1'b0, 1'b1, 2'h2), d);
      $display("test reset_state done");
      for (int i = 0; i < 4; i++)
         fire_run(2'(i), 1'(i));
      fire_run(2'h0, 1'b1);
      fire_run(2'h3, 1'b0);
      // Enable read during the fire pulse is refused and shows firing
      set_straps(2'h0, 1'b1);
      iorw_host_model_inst.rd(16'h0443, d, oe);
      for (int k = 0; k < 100 && nmi_o !== 1'b1; k++)
         @(negedge core_clk);
      cmp_v(8'h01, {7'h0, nmi_o});
      iorw_host_model_inst.rd(16'h0443, d, oe);
      cmp_v(8'h06, d);
      repeat (40) @(negedge core_clk);
      quiet(100);
      $display("test timeout done");
      set_straps(2'h1, 1'b0);
      iorw_host_model_inst.rd(16'h0443, d, oe);
      f0 = fires;
      // Refresh gap stays below 70 percent of the shortest period
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         repeat (rnd[2:0]) @(negedge core_clk);
         iorw_host_model_inst.rd(16'h0443, d, oe);
         cmp_v(status(1'b1, 1'b0, 2'h1), d);
         cmp_v(8'h01, {7'h0, oe});
      end
      cmp_v(8'h00, 8'(fires - f0));
      iorw_host_model_inst.rd(16'h0043, d, oe);
      quiet(200);
      $display("test refresh_disable done");
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         iorw_host_model_inst.rd(rnd[15:0] | 16'h1000, d, oe);
         cmp_v(8'h00, {7'h0, oe});
      end
      quiet(150);
      $display("test other_address done");
      iorw_host_model_inst.rd(16'h0443, d, oe);
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      quiet(150);
      $display("test mid_run_reset done");
      end_sim();
   end
endmodule

`default_nettype wire
